// ### hdl/rss_consts.vh
// Purpose: Constants for the reset source sequencer.
// Assumes: APB byte addresses; 200 MHz mclk (5 ns period).
// Notes: Register map and reset/timing constants follow.
`ifndef RSS_CONSTS_VH
`define RSS_CONSTS_VH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define RSS_ADDR_SUPPLY_CTRL 8'hFF
`define RSS_ADDR_CAUSE 8'h00
`define RSS_ADDR_CORE 8'h04
`define RSS_ADDR_STATUS 8'h08
`define RSS_SUPPLY_ON_BIT 7
`define RSS_SUPPLY_ABOVE_RST_BIT 6
`define RSS_SUPPLY_WARN_OK_BIT 5
`define RSS_CAUSE_CLKLOSS_BIT 2
`define RSS_CAUSE_POWER_BIT 1
`define RSS_CAUSE_PIN_BIT 0
`define RSS_CORE_SLEEP_BIT 0
`define RSS_CORE_SUSPEND_BIT 1
`define RSS_CORE_FLASHWR_BIT 2

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define RSS_PORT_RESET 8'hFF
`define RSS_PC_RESET 16'h0000
`define RSS_WDT_DIV 4'hC
`define RSS_CLK_MHZ 200
`define RSS_POR_DLY_LO_MS 3
`define RSS_POR_DLY_MID_MS 7
`define RSS_POR_DLY_HI_MS 15
`define RSS_CLKLOSS_US 100
`define RSS_CLKLOSS_CYC (`RSS_CLKLOSS_US * `RSS_CLK_MHZ)
`define RSS_STRETCH_CYC 5'h10

`endif

// ### hdl/rss_reset_source_sequencer.v
// Purpose: Reset source sequencer with APB register access.
// Assumes: Analog comparator levels arrive synchronous to mclk.
// Notes: Clock-loss timing is made from an activity strobe from the clock monitor.
`timescale 1ns/1ps
`include "rss_consts.vh"

module rss_reset_source_sequencer #(
	parameter POR_LO_CYC = `RSS_POR_DLY_LO_MS * 1000 * `RSS_CLK_MHZ,
	parameter POR_MID_CYC = `RSS_POR_DLY_MID_MS * 1000 * `RSS_CLK_MHZ,
	parameter POR_HI_CYC = `RSS_POR_DLY_HI_MS * 1000 * `RSS_CLK_MHZ,
	parameter CLKLOSS_CYC = `RSS_CLKLOSS_CYC
) (
	input wire mclk,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire above_power_on_threshold,
	input wire above_reset_threshold,
	input wire above_warning_threshold,
	input wire [1:0] supply_level,
	input wire clock_activity,
	input wire reset_pin_n_in,
	output reg reset_pin_n_out,
	output reg reset_pin_oe_n,
	output reg core_reset,
	output reg [15:0] pc_reset_value,
	output reg internal_osc_sel,
	output reg watchdog_on,
	output reg [3:0] watchdog_div,
	output reg [7:0] port_latch,
	output reg port_open_drain,
	output reg port_weak_pullup,
	output reg intr_timer_off,
	output reg early_warning_irq
);

	// States, one hot.
	localparam [3:0] ST_POR = 4'b0001;
	localparam [3:0] ST_DELAY = 4'b0010;
	localparam [3:0] ST_HOLD = 4'b0100;
	localparam [3:0] ST_RUN = 4'b1000;
	localparam [2:0] SRC_NONE = 3'h0;
	localparam [2:0] SRC_PFAIL = 3'h1;
	localparam [2:0] SRC_PIN = 3'h2;
	localparam [2:0] SRC_CLK = 3'h3;
	localparam [2:0] SRC_FLASH = 3'h4;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Selects the power-on delay count for the present supply level.
	function [31:0] por_delay;
		input [1:0] lvl;
		begin
			case (lvl)
				2'h0: por_delay = POR_LO_CYC;
				2'h1: por_delay = POR_MID_CYC;
				default: por_delay = POR_HI_CYC;
			endcase
		end
	endfunction

	reg [3:0] state_q;
	reg [31:0] cnt_q;
	reg [4:0] stretch_q;
	reg [2:0] src_q;
	reg mon_on_q;
	reg mon_sel_q;
	reg clk_en_q;
	reg flag_pow_q;
	reg flag_pin_q;
	reg flag_clk_q;
	reg sleep_q;
	reg suspend_q;
	reg pin_s1_q;
	reg pin_s2_q;
	reg [31:0] idle_q;
	reg pin_drv_q;

	wire low_power = sleep_q | suspend_q;
	wire pin_low = ~pin_s2_q;
	wire pfail_hit = mon_on_q & mon_sel_q & ~sleep_q & ~above_reset_threshold;
	wire clk_hit = clk_en_q & ~low_power & (idle_q >= CLKLOSS_CYC);
	wire apb_wr = psel & penable & pwrite & pready;
	wire flash_wr = apb_wr & (paddr == `RSS_ADDR_CORE) & pwdata[`RSS_CORE_FLASHWR_BIT];
	wire flash_hit = flash_wr & ~mon_on_q;

	// ------------------------------------------------------------------
	// Pin synchroniser and clock-loss timer
	// ------------------------------------------------------------------
	// Double flop on the external reset pin; only the second flop is used.
	always @(posedge mclk) begin
		pin_s1_q <= reset_pin_n_in;
		pin_s2_q <= pin_s1_q;
		if (clock_activity | ~clk_en_q | low_power) begin
			idle_q <= 32'h0;
		end else if (idle_q < CLKLOSS_CYC) begin
			idle_q <= idle_q + 32'h1;
		end
	end

	// ------------------------------------------------------------------
	// Reset sequencer
	// ------------------------------------------------------------------
	// Chooses the reset cause, holds the core and releases it in order.
	always @(posedge mclk) begin
		if (sys_rst) begin
			state_q <= ST_POR;
			cnt_q <= 32'h0;
			stretch_q <= `RSS_STRETCH_CYC;
			src_q <= SRC_NONE;
			mon_on_q <= 1'b1;
			mon_sel_q <= 1'b1;
			clk_en_q <= 1'b0;
			flag_pow_q <= 1'b0;
			flag_pin_q <= 1'b0;
			flag_clk_q <= 1'b0;
			sleep_q <= 1'b0;
			suspend_q <= 1'b0;
			pin_drv_q <= 1'b1;
		end else begin
			case (state_q)
				ST_POR: begin
					pin_drv_q <= 1'b1;
					mon_on_q <= 1'b1;
					mon_sel_q <= 1'b1;
					if (above_power_on_threshold) begin
						state_q <= ST_DELAY;
						cnt_q <= por_delay(supply_level);
					end
				end
				ST_DELAY: begin
					if (!above_power_on_threshold) begin
						state_q <= ST_POR;
					end else if (cnt_q == 32'h0) begin
						// Release our own pin drive first and wait until the
						// synchronised pin reads high, so it is not seen as a pin reset.
						if (pin_drv_q || pin_low) begin
							pin_drv_q <= 1'b0;
						end else begin
							state_q <= ST_RUN;
							flag_pow_q <= 1'b1;
							flag_pin_q <= 1'b0;
							flag_clk_q <= 1'b0;
							stretch_q <= `RSS_STRETCH_CYC;
						end
					end else begin
						cnt_q <= cnt_q - 32'h1;
					end
				end
				ST_HOLD: begin
					// Power fail leaves without the power-on delay.
					if (src_q == SRC_PFAIL) begin
						mon_on_q <= 1'b1;
						mon_sel_q <= 1'b1;
					end
					if (!above_power_on_threshold) begin
						state_q <= ST_POR;
					end else if (src_q == SRC_PFAIL && !above_reset_threshold) begin
						stretch_q <= `RSS_STRETCH_CYC;
					end else if (src_q == SRC_PIN && pin_low) begin
						stretch_q <= `RSS_STRETCH_CYC;
					end else if (stretch_q != 5'h0) begin
						stretch_q <= stretch_q - 5'h1;
					end else if (pin_drv_q || pin_low) begin
						// Our own low drive must clear the synchroniser before exit.
						pin_drv_q <= 1'b0;
					end else begin
						state_q <= ST_RUN;
						flag_pow_q <= (src_q == SRC_PFAIL);
						flag_pin_q <= (src_q == SRC_PIN);
						flag_clk_q <= (src_q == SRC_CLK);
						stretch_q <= `RSS_STRETCH_CYC;
					end
				end
				ST_RUN: begin
					if (!above_power_on_threshold) begin
						state_q <= ST_POR;
					end else if (pin_low) begin
						state_q <= ST_HOLD;
						src_q <= SRC_PIN;
					end else if (pfail_hit) begin
						state_q <= ST_HOLD;
						src_q <= SRC_PFAIL;
						pin_drv_q <= 1'b1;
					end else if (clk_hit) begin
						state_q <= ST_HOLD;
						src_q <= SRC_CLK;
					end else if (flash_hit) begin
						state_q <= ST_HOLD;
						src_q <= SRC_FLASH;
					end
					if (!pin_low && !pfail_hit && !clk_hit && !flash_hit && apb_wr) begin
						case (paddr)
							`RSS_ADDR_SUPPLY_CTRL: begin
								mon_on_q <= pwdata[`RSS_SUPPLY_ON_BIT];
							end
							`RSS_ADDR_CAUSE: begin
								mon_sel_q <= pwdata[`RSS_CAUSE_POWER_BIT];
								clk_en_q <= pwdata[`RSS_CAUSE_CLKLOSS_BIT];
							end
							`RSS_ADDR_CORE: begin
								sleep_q <= pwdata[`RSS_CORE_SLEEP_BIT];
								suspend_q <= pwdata[`RSS_CORE_SUSPEND_BIT];
							end
							default: begin
							end
						endcase
					end
				end
				default: begin
					state_q <= ST_POR;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Core-facing outputs
	// ------------------------------------------------------------------
	// Drives the reset-state and exit values to the core and ports.
	always @(posedge mclk) begin
		if (sys_rst) begin
			core_reset <= 1'b1;
			reset_pin_n_out <= 1'b0;
			reset_pin_oe_n <= 1'b0;
			pc_reset_value <= `RSS_PC_RESET;
			internal_osc_sel <= 1'b1;
			watchdog_on <= 1'b1;
			watchdog_div <= `RSS_WDT_DIV;
			port_latch <= `RSS_PORT_RESET;
			port_open_drain <= 1'b1;
			port_weak_pullup <= 1'b1;
			intr_timer_off <= 1'b1;
			early_warning_irq <= 1'b0;
		end else begin
			core_reset <= (state_q != ST_RUN);
			reset_pin_n_out <= 1'b0;
			reset_pin_oe_n <= ~pin_drv_q;
			pc_reset_value <= `RSS_PC_RESET;
			internal_osc_sel <= 1'b1;
			watchdog_on <= 1'b1;
			watchdog_div <= `RSS_WDT_DIV;
			port_latch <= `RSS_PORT_RESET;
			port_open_drain <= 1'b1;
			port_weak_pullup <= 1'b1;
			intr_timer_off <= (state_q != ST_RUN);
			early_warning_irq <= ~above_warning_threshold;
		end
	end

	// ------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------
	// No wait states; unmapped addresses read zero with pslverr.
	always @(posedge mclk) begin
		if (sys_rst) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			if (psel && !penable) begin
				case (paddr)
					`RSS_ADDR_SUPPLY_CTRL: begin
						prdata <= {24'h0, mon_on_q, above_reset_threshold,
							above_warning_threshold, 5'h00};
					end
					`RSS_ADDR_CAUSE: begin
						prdata <= {29'h0, flag_clk_q | (clk_en_q & ~flag_pow_q),
							flag_pow_q, flag_pin_q};
					end
					`RSS_ADDR_CORE: begin
						prdata <= {30'h0, suspend_q, sleep_q};
					end
					`RSS_ADDR_STATUS: begin
						prdata <= {24'h0, src_q, mon_sel_q, state_q};
					end
					default: begin
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

endmodule // rss_reset_source_sequencer

// ### testbench/rss_checker.sv
// Purpose: Port assertions for the reset source sequencer.
// Assumes: One clock domain with a synchronous reset.
// Notes: Attached to every sequencer by the bind below.
`timescale 1ns/1ps
module rss_checker (
	input wire mclk,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pready,
	input wire above_warning_threshold,
	input wire reset_pin_n_in,
	input wire reset_pin_n_out,
	input wire reset_pin_oe_n,
	input wire core_reset,
	input wire [15:0] pc_reset_value,
	input wire internal_osc_sel,
	input wire watchdog_on,
	input wire [3:0] watchdog_div,
	input wire [7:0] port_latch,
	input wire port_open_drain,
	input wire port_weak_pullup,
	input wire intr_timer_off,
	input wire early_warning_irq
);
	// Every check shares the system clock and is off during reset.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	chk_pin_only_reset:
	assert property (!reset_pin_oe_n |-> !reset_pin_n_out && core_reset) else $error("pin drive");
	chk_port_safe_state:
	assert property (core_reset |-> port_latch == 8'hFF && port_open_drain && port_weak_pullup)
		else $error("port state");
	chk_exit_fetch_state:
	assert property ($fell(core_reset) |-> pc_reset_value == 16'h0000 && internal_osc_sel)
		else $error("exit state");
	chk_watchdog_on_exit:
	assert property ($fell(core_reset) |-> watchdog_on && watchdog_div == 4'hC)
		else $error("watchdog");
	chk_irq_timer_off:
	assert property (intr_timer_off == core_reset) else $error("timers");
	chk_warn_flag_low:
	assert property ($fell(above_warning_threshold) |=> early_warning_irq) else $error("warn");
	chk_pin_forces_reset:
	assert property ($fell(reset_pin_n_in) |-> ##[1:4] core_reset) else $error("pin reset");
	chk_reset_stretched:
	assert property ($rose(core_reset) |-> core_reset [*8]) else $error("stretch");
	chk_ready_one_cycle:
	assert property (pready |=> !pready) else $error("ready width");
	chk_ready_after_setup:
	assert property (psel && !penable |=> pready) else $error("ready late");
	// Main scenarios reached.
	cover property ($fell(core_reset));
	cover property ($fell(reset_pin_n_in) && !core_reset);
	cover property ($rose(early_warning_irq));
endmodule // rss_checker
bind rss_reset_source_sequencer rss_checker chk_u (.mclk, .sys_rst, .psel, .penable, .pready,
	.above_warning_threshold, .reset_pin_n_in, .reset_pin_n_out, .reset_pin_oe_n, .core_reset,
	.pc_reset_value, .internal_osc_sel, .watchdog_on, .watchdog_div, .port_latch,
	.port_open_drain, .port_weak_pullup, .intr_timer_off, .early_warning_irq);

// ### testbench/rss_pin_partner.sv
// Purpose: External reset circuit on the active-low reset pin.
// Assumes: The pin has a pull-up; both parties only pull it low.
// Notes: Holds the pin low for the asked number of cycles.
`timescale 1ns/1ps
module rss_pin_partner (
	input wire mclk,
	input wire start,
	input wire [7:0] hold_cycles,
	input wire dev_pin_out,
	input wire dev_pin_oe_n,
	output wire pin_n
);
	logic [7:0] left_q = 8'h00;
	// Counts down the low pulse that the bench asks for.
	always @(posedge mclk) begin
		if (start) begin
			left_q <= hold_cycles;
		end else if (left_q != 8'h00) begin
			left_q <= left_q - 8'h01;
		end
	end
	// Wired level: low when either party pulls, else the pull-up wins.
	assign pin_n = !((left_q != 8'h00) || (!dev_pin_oe_n && !dev_pin_out));
endmodule // rss_pin_partner

// ### testbench/testbench.sv
// Purpose: Self-checking bench for the reset source sequencer.
// Assumes: Shortened power-on and clock-loss counts.
// Notes: Registers are reached through APB tasks.
`timescale 1ns/1ps
`include "rss_consts.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
	localparam int POR_CYC = 200;
	logic mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic por_ok = 0, rst_ok = 0, warn_ok = 1, act = 1, pin_go = 0;
	logic [1:0] lvl = 2'h0;
	logic pin_n, pin_out, pin_oe_n, core_reset;
	int n_errors = 0, n_compared = 0, cyc;
	rss_reset_source_sequencer #(.POR_LO_CYC(POR_CYC), .POR_MID_CYC(400), .POR_HI_CYC(600),
		.CLKLOSS_CYC(50)) dut_u (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .above_power_on_threshold(por_ok),
		.above_reset_threshold(rst_ok), .above_warning_threshold(warn_ok), .supply_level(lvl),
		.clock_activity(act), .reset_pin_n_in(pin_n), .reset_pin_n_out(pin_out),
		.reset_pin_oe_n(pin_oe_n), .core_reset, .pc_reset_value(), .internal_osc_sel(),
		.watchdog_on(), .watchdog_div(), .port_latch(), .port_open_drain(),
		.port_weak_pullup(), .intr_timer_off(), .early_warning_irq());
	rss_pin_partner pin_u (.mclk, .start(pin_go), .hold_cycles(8'h06), .dev_pin_out(pin_out),
		.dev_pin_oe_n(pin_oe_n), .pin_n);
	// Free-running system clock.
	initial begin
		forever #2.5 mclk = ~mclk;
	end
	// Prints the counts and the verdict, then stops.
	task automatic give_verdict;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// One APB transfer; the request holds until pready is sampled high.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		do begin
			@(posedge mclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		if (i >= 20) begin n_errors++; give_verdict(); end
		@(posedge mclk);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus(0, a, 32'h00000000);
		`CHK(nm, e, rd)
	endtask
	// Waits for the core reset level, counting edges in cyc.
	task automatic wait_rst(input logic v);
		for (cyc = 0; core_reset !== v; cyc++) begin
			@(posedge mclk);
			if (cyc > 2000) begin n_errors++; give_verdict(); end
		end
	endtask
	// Main sequence: power-on, pin, power-fail, clock loss, flash error.
	initial begin
		repeat (12) @(posedge mclk);
		sys_rst <= 0;
		repeat (30) @(posedge mclk);
		`CHK("por hold", 2'b10, {core_reset, pin_n})
		por_ok <= 1;
		rst_ok <= 1;
		@(posedge mclk);
		wait_rst(0);
		`CHK("por delay", 1'b1, cyc >= POR_CYC)
		rd_chk(`RSS_ADDR_CAUSE, 32'h02, "cause por");
		rd_chk(`RSS_ADDR_SUPPLY_CTRL, 32'hE0, "supply ctrl");
		warn_ok <= 0;
		repeat (3) @(posedge mclk);
		rd_chk(`RSS_ADDR_SUPPLY_CTRL, 32'hC0, "warn low");
		warn_ok <= 1;
		bus(0, 8'h10, 32'h00000000);
		`CHK("unmapped", 1'b1, err)
		pin_go <= 1;
		@(posedge mclk);
		pin_go <= 0;
		wait_rst(1);
		`CHK("pin not driven", 1'b1, pin_oe_n)
		wait_rst(0);
		rd_chk(`RSS_ADDR_CAUSE, 32'h01, "cause pin");
		bus(1, `RSS_ADDR_CORE, 32'h01);
		rst_ok <= 0;
		repeat (40) @(posedge mclk);
		`CHK("sleep no fail", 1'b0, core_reset)
		rst_ok <= 1;
		bus(1, `RSS_ADDR_CORE, 32'h00);
		rst_ok <= 0;
		wait_rst(1);
		repeat (20) @(posedge mclk);
		`CHK("fail held", 2'b10, {core_reset, pin_n})
		rst_ok <= 1;
		wait_rst(0);
		`CHK("no por delay", 1'b1, cyc < POR_CYC)
		rd_chk(`RSS_ADDR_CAUSE, 32'h02, "cause fail");
		bus(1, `RSS_ADDR_CAUSE, 32'h06);
		act <= 0;
		wait_rst(1);
		act <= 1;
		`CHK("clk loss", 2'b11, {cyc > 50, pin_n})
		wait_rst(0);
		rd_chk(`RSS_ADDR_CAUSE, 32'h04, "cause clk");
		bus(1, `RSS_ADDR_CAUSE, 32'h02);
		act <= 0;
		repeat (80) @(posedge mclk);
		`CHK("clk loss off", 1'b0, core_reset)
		act <= 1;
		bus(1, `RSS_ADDR_SUPPLY_CTRL, 32'h00);
		bus(1, `RSS_ADDR_CORE, 32'h04);
		wait_rst(1);
		`CHK("flash reset", 1'b1, core_reset)
		wait_rst(0);
		rd_chk(`RSS_ADDR_SUPPLY_CTRL, 32'h60, "monitor kept");
		bus(1, `RSS_ADDR_SUPPLY_CTRL, 32'h80);
		bus(1, `RSS_ADDR_CAUSE, 32'h02);
		rd_chk(`RSS_ADDR_SUPPLY_CTRL, 32'hE0, "monitor back on");
		give_verdict();
	end
endmodule // testbench
